// *** rtl/fclc_pkg.sv ***
// Package of constants for the flash command launch control block
// Notes on behaviour
// [R1] Busy: refuse launch, drop buffer writes
// [R2] Software clears error flags before launch
// [R3] Writing 1 to flag clears it, launches
// [R4] Flag stays clear until done, results returned
// [R5] Buffer access goes to indexed parameter field
// [R6] Failed prerequisite: no execute, set access error
// [R7] Software avoids register writes while busy
// [R8] Error interrupt only when enable bit set
// [R9] Complete interrupt requested when flag sets
// [R10] Flag set after reset, no command active
package fclc_pkg;
  // ==========================================================
  // Buffer geometry
  localparam int unsigned FCLC_NUM_FIELDS  = 8;
  localparam int unsigned FCLC_IDX_W       = 3;
  localparam int unsigned FCLC_DATA_W      = 16;
  localparam int unsigned FCLC_ERR_W       = 2;
  // ==========================================================
  // Reset values
  localparam logic        FCLC_CCF_RST     = 1'b1;
  localparam logic [15:0] FCLC_FIELD_RST   = 16'h0000;
  localparam logic [2:0]  FCLC_IDX_RST     = 3'h0;
  localparam logic [1:0]  FCLC_ERR_RST     = 2'h0;
  // ==========================================================
  // Execution timing
  localparam int unsigned FCLC_CLK_MHZ     = 250;
  localparam int unsigned FCLC_EXEC_NS     = 40;
  localparam int unsigned FCLC_EXEC_CYC    = (FCLC_EXEC_NS * FCLC_CLK_MHZ + 999) / 1000;
  localparam int unsigned FCLC_CNT_W       = 16;
  // ==========================================================
  // Controller states
  typedef enum logic [1:0] {FCLC_IDLE, FCLC_RUN, FCLC_DONE} fclc_state_e;
endpackage : fclc_pkg

// *** rtl/fclc_param_buffer.sv ***
// Indexed command parameter buffer storage
`timescale 1ns/1ps
module fclc_param_buffer
  import fclc_pkg::*;
#(
  parameter int unsigned DEPTH = FCLC_NUM_FIELDS,
  parameter int unsigned IDX_W = FCLC_IDX_W,
  parameter int unsigned DW    = FCLC_DATA_W
)(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             sw_we_in,
  input  wire logic [IDX_W-1:0] sw_idx_in,
  input  wire logic [DW-1:0]    sw_data_in,
  input  wire logic             res_we_in,
  input  wire logic [IDX_W-1:0] res_idx_in,
  input  wire logic [DW-1:0]    res_data_in,
  input  wire logic [IDX_W-1:0] rd_idx_in,
  output logic      [DW-1:0]    rd_data_out
);
  logic [DW-1:0] field_q [DEPTH];

  // ==========================================================
  // Storage: result writes from the controller win over software
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < DEPTH; i++) field_q[i] <= FCLC_FIELD_RST;
    end
    else if (res_we_in)
      field_q[res_idx_in] <= res_data_in;
    else if (sw_we_in)
      field_q[sw_idx_in] <= sw_data_in; // [R5]
  end

  // Read reaches the selected field
  assign rd_data_out = field_q[rd_idx_in]; // [R5]
endmodule : fclc_param_buffer

// *** rtl/fclc_top.sv ***
// Command launch and completion handshake of the flash controller
`timescale 1ns/1ps
module fclc_top
  import fclc_pkg::*;
#(
  parameter int unsigned EXEC_CYCLES = FCLC_EXEC_CYC
)(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   idx_we_in,
  input  wire logic [FCLC_IDX_W-1:0]  idx_data_in,
  input  wire logic                   buf_we_in,
  input  wire logic [FCLC_DATA_W-1:0] buf_data_in,
  input  wire logic                   ccf_w1_in,
  input  wire logic                   err_w1c_in,
  input  wire logic                   pviol_w1c_in,
  input  wire logic                   cie_we_in,
  input  wire logic                   cie_data_in,
  input  wire logic                   ecfg_we_in,
  input  wire logic [FCLC_ERR_W-1:0]  ecfg_data_in,
  input  wire logic [FCLC_ERR_W-1:0]  efault_set_in,
  input  wire logic [FCLC_ERR_W-1:0]  estat_w1c_in,
  input  wire logic                   prereq_ok_in,
  input  wire logic                   prot_hit_in,
  output logic                        command_complete_flag_out,
  output logic                        access_error_flag_out,
  output logic                        protection_violation_flag_out,
  output logic [FCLC_IDX_W-1:0]       parameter_index_field_out,
  output logic [FCLC_DATA_W-1:0]      buf_rd_data_out,
  output logic                        complete_interrupt_enable_out,
  output logic [FCLC_ERR_W-1:0]       error_config_out,
  output logic [FCLC_ERR_W-1:0]       error_status_out,
  output logic                        cmd_irq_out,
  output logic                        err_irq_out,
  output logic                        exec_active_out
);
  fclc_state_e                state_q, state_d;
  logic                       ccf_q, access_error_flag_q, pviol_q, cie_q, cmd_irq_q, err_irq_q;
  logic [FCLC_IDX_W-1:0]      idx_q;
  logic [FCLC_ERR_W-1:0]      ecfg_q, estat_q;
  logic [FCLC_CNT_W-1:0]      cnt_q;
  logic [FCLC_DATA_W-1:0]     rd_data, rd_q;
  logic [FCLC_DATA_W-1:0]     cmd_word_q;
  logic                       exec_q;
  logic [FCLC_ERR_W-1:0]      estat_d;

  // ==========================================================
  // Helpers
  // Next value of a write-one-to-clear flag bit. A hardware set that lands
  // in the same cycle as a software clear wins, so an event is never lost.
  function automatic logic sticky_next(
    input logic cur,
    input logic clr,
    input logic set
  );
    sticky_next = (cur & ~clr) | set;
  endfunction : sticky_next

  // ==========================================================
  // Decode of launch and buffer writes
  wire idle      = (state_q == FCLC_IDLE);
  wire errs_set  = access_error_flag_q | pviol_q;
  wire launch    = ccf_w1_in & ccf_q & idle;             // [R1] [R3]
  wire bad_start = launch & (errs_set | ~prereq_ok_in | prot_hit_in);
  wire good_start = launch & ~bad_start;
  wire buf_wr_ok = buf_we_in & ccf_q;                    // [R1]
  wire cnt_done  = (cnt_q == FCLC_CNT_W'(EXEC_CYCLES - 1));
  wire done      = (state_q == FCLC_DONE);
  wire ccf_rise  = done;                                 // Flag returns to 1 next edge
  // Next values of flags and config, so the error interrupt uses the same timing as the outputs
  wire access_error_flag_d  = sticky_next(access_error_flag_q, err_w1c_in, bad_start);          // [R6]
  wire pviol_d   = sticky_next(pviol_q, pviol_w1c_in, launch & prot_hit_in);
  wire cfg_ok    = ccf_q;                                // Config writes only while idle
  wire [FCLC_ERR_W-1:0] ecfg_d = (ecfg_we_in && cfg_ok) ? ecfg_data_in : ecfg_q;
  wire field0_wr = buf_wr_ok & (idx_q == FCLC_IDX_RST);  // Software write to the command word field

  // Status bits of the error register, one sticky bit each
  always_comb
  begin
    for (int b = 0; b < FCLC_ERR_W; b++)
      estat_d[b] = sticky_next(estat_q[b], estat_w1c_in[b], efault_set_in[b]);
  end

  // ==========================================================
  // Sequencer: a launch that fails its prerequisite never runs
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FCLC_IDLE: if (good_start) state_d = FCLC_RUN;     // [R6]
      FCLC_RUN:  if (cnt_done) state_d = FCLC_DONE;
      FCLC_DONE: state_d = FCLC_IDLE;
      default:   state_d = FCLC_IDLE;
    endcase
  end

  // Buffer storage, addressed through the index register
  fclc_param_buffer u_buf (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .sw_we_in    (buf_wr_ok),
    .sw_idx_in   (idx_q),
    .sw_data_in  (buf_data_in),
    .res_we_in   (done),
    .res_idx_in  (FCLC_IDX_RST),
    .res_data_in (~cmd_word_q),
    .rd_idx_in   (idx_q),
    .rd_data_out (rd_data)
  );

  // ==========================================================
  // Sequencer state
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_q <= FCLC_IDLE;
    else
      state_q <= state_d;
  end

  // Command complete flag: cleared by an accepted launch, held low through
  // the run and set again as the controller finishes
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ccf_q <= FCLC_CCF_RST;                             // [R10]
    else if (good_start)
      ccf_q <= 1'b0;                                     // [R3] [R4]
    else if (ccf_rise)
      ccf_q <= 1'b1;                                     // [R4]
  end

  // Busy indication kept in its own flop so the output has no inverter
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      exec_q <= 1'b0;
    else if (good_start)
      exec_q <= 1'b1;                                    // [R4]
    else if (ccf_rise)
      exec_q <= 1'b0;
  end

  // Error flags; set wins over clear so a refused launch is always seen
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      access_error_flag_q <= 1'b0;
      pviol_q  <= 1'b0;
      estat_q  <= FCLC_ERR_RST;
    end
    else
    begin
      access_error_flag_q <= access_error_flag_d;                              // [R6]
      pviol_q  <= pviol_d;                               // [R6]
      estat_q  <= estat_d;
    end
  end

  // Configuration and index; writes during a run are dropped, since the
  // running command must not see its setup change under it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cie_q  <= 1'b0;
      ecfg_q <= FCLC_ERR_RST;
      idx_q  <= FCLC_IDX_RST;
    end
    else
    begin
      if (cie_we_in && cfg_ok)
        cie_q <= cie_data_in;
      ecfg_q <= ecfg_d;
      if (idx_we_in && cfg_ok)
        idx_q <= idx_data_in;                            // [R1] [R5]
    end
  end

  // Execution counter, restarted by every accepted launch
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cnt_q <= '0;
    else if (good_start)
      cnt_q <= '0;
    else if (state_q == FCLC_RUN)
      cnt_q <= cnt_q + 1'b1;
  end

  // Copy of field 0 as the controller sees it: follows software writes
  // while idle and takes the result on completion, so it always matches
  // the buffer whatever the index holds at launch, without a second read port
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cmd_word_q <= FCLC_FIELD_RST;
    else if (done)
      cmd_word_q <= ~cmd_word_q;                         // [R4]
    else if (field0_wr)
      cmd_word_q <= buf_data_in;                         // [R3]
  end

  // Read data and interrupt requests, registered for clean outputs
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_q      <= FCLC_FIELD_RST;
      cmd_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
    end
    else
    begin
      rd_q      <= rd_data;                              // [R5]
      cmd_irq_q <= cie_q & (ccf_q | ccf_rise);           // [R9]
      err_irq_q <= |(estat_d & ecfg_d);                  // [R8]
    end
  end

  // ==========================================================
  // Registered outputs
  assign command_complete_flag_out     = ccf_q;
  assign access_error_flag_out         = access_error_flag_q;
  assign protection_violation_flag_out = pviol_q;
  assign parameter_index_field_out     = idx_q;
  assign buf_rd_data_out               = rd_q;
  assign complete_interrupt_enable_out = cie_q;
  assign error_config_out              = ecfg_q;
  assign error_status_out              = estat_q;
  assign cmd_irq_out                   = cmd_irq_q;
  assign err_irq_out                   = err_irq_q;
  assign exec_active_out               = exec_q;
endmodule : fclc_top

// *** sim/fclc_checker.sv ***
// Assertion checker for the flash command launch control block
`timescale 1ns/1ps
module fclc_checker
  import fclc_pkg::*;
#(
  parameter int unsigned EXEC_CYCLES = FCLC_EXEC_CYC
)(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  idx_we_in,
  input  wire logic                  ccf_w1_in,
  input  wire logic                  prereq_ok_in,
  input  wire logic                  prot_hit_in,
  input  wire logic                  command_complete_flag_out,
  input  wire logic                  access_error_flag_out,
  input  wire logic                  protection_violation_flag_out,
  input  wire logic [FCLC_IDX_W-1:0] parameter_index_field_out,
  input  wire logic                  complete_interrupt_enable_out,
  input  wire logic [FCLC_ERR_W-1:0] error_config_out,
  input  wire logic [FCLC_ERR_W-1:0] error_status_out,
  input  wire logic                  cmd_irq_out,
  input  wire logic                  err_irq_out,
  input  wire logic                  exec_active_out
);
  // ==========================================================
  // Busy length counter; a counter keeps long counts out of repetitions
  logic [FCLC_CNT_W-1:0] low_cnt_q;
  wire logic             go_ok = ccf_w1_in && prereq_ok_in && !prot_hit_in && !access_error_flag_out
                                 && !protection_violation_flag_out;
  wire logic             ccf = command_complete_flag_out;
  wire logic             eact = (error_status_out & error_config_out) != 2'h0;
  always_ff @(posedge clk_in)
    if (rst_in || ccf) low_cnt_q <= '0;
    else low_cnt_q <= low_cnt_q + 1'b1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Launch needs a settled idle flag, so a completion edge is not taken as idle
  sequence s_launch; go_ok && ccf && $past(ccf); endsequence
  property p_launch; s_launch |=> !ccf; endproperty
  a_launch: assert property (p_launch) else $error("launch did not clear flag");
  // A rise forced by reset ends no command, so it is not measured
  property p_len; $rose(ccf) && !$past(rst_in) |-> low_cnt_q == EXEC_CYCLES + 1; endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_max; low_cnt_q <= EXEC_CYCLES + 1; endproperty
  a_max: assert property (p_max) else $error("busy too long");
  property p_idx; !ccf && idx_we_in |=> $stable(parameter_index_field_out); endproperty
  a_idx: assert property (p_idx) else $error("index written while busy");
  property p_acc; ccf_w1_in && ccf && !prereq_ok_in |=> access_error_flag_out && ccf; endproperty
  a_acc: assert property (p_acc) else $error("no access error");
  property p_pv; ccf_w1_in && ccf && prot_hit_in |=> protection_violation_flag_out; endproperty
  a_pv: assert property (p_pv) else $error("no protection violation");
  property p_cion; $rose(ccf) && complete_interrupt_enable_out |=> cmd_irq_out; endproperty
  a_cion: assert property (p_cion) else $error("no complete interrupt");
  property p_cioff; !complete_interrupt_enable_out && !$past(complete_interrupt_enable_out) |-> !cmd_irq_out; endproperty
  a_cioff: assert property (p_cioff) else $error("complete interrupt while disabled");
  property p_eoff; !eact && !$past(eact) |-> !err_irq_out; endproperty
  a_eoff: assert property (p_eoff) else $error("error interrupt while disabled");
  property p_rst; $fell(rst_in) |-> ccf; endproperty
  a_rst: assert property (p_rst) else $error("flag clear after reset");
  property p_exec; exec_active_out == !ccf; endproperty
  a_exec: assert property (p_exec) else $error("busy output disagrees with flag");
  property p_eon; eact |-> err_irq_out; endproperty
  a_eon: assert property (p_eon) else $error("enabled error without interrupt");
endmodule : fclc_checker
bind fclc_top fclc_checker #(.EXEC_CYCLES(EXEC_CYCLES)) u_chk (.*);

// *** sim/fclc_tb.sv ***
// Self-checking testbench for the flash command launch control block
`timescale 1ns/1ps
module testbench
  import fclc_pkg::*;
;
  // ==========================================================
  // Short execution keeps the run brief
  localparam int unsigned EXC = 2;
  logic clk_in = 1'b0, rst_in = 1'b1, idx_we_in = 1'b0, buf_we_in = 1'b0, ccf_w1_in = 1'b0, err_w1c_in = 1'b0;
  logic pviol_w1c_in = 1'b0, cie_we_in = 1'b0, cie_data_in = 1'b0, ecfg_we_in = 1'b0, prereq_ok_in = 1'b1;
  logic prot_hit_in = 1'b0;
  logic [2:0] idx_data_in = 3'h0;
  logic [15:0] buf_data_in = 16'h0000;
  logic [1:0] ecfg_data_in = 2'h0, efault_set_in = 2'h0, estat_w1c_in = 2'h0;
  logic command_complete_flag_out, access_error_flag_out, protection_violation_flag_out, complete_interrupt_enable_out;
  logic cmd_irq_out, err_irq_out, exec_active_out;
  logic [2:0] parameter_index_field_out;
  logic [15:0] buf_rd_data_out;
  logic [1:0] error_config_out, error_status_out;
  int err_total = 0, num_checks = 0;
  fclc_top #(.EXEC_CYCLES(EXC)) DUT (.*);
  initial forever #2 clk_in = ~clk_in;
  // Inputs move 1 ns after the edge so sampling never races
  task automatic tk(input int n = 1);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tk
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin err_total++; $display("mismatch %0t exp %h got %h", $time, e, g); end
  endtask : chk16
  task automatic chk1(input logic e, input logic g);
    chk16({15'h0, e}, {15'h0, g});
  endtask : chk1
  task automatic wr_idx(input logic [2:0] v);
    idx_data_in = v; idx_we_in = 1'b1; tk(); idx_we_in = 1'b0;
  endtask : wr_idx
  task automatic wr_buf(input logic [15:0] v);
    buf_data_in = v; buf_we_in = 1'b1; tk(); buf_we_in = 1'b0;
  endtask : wr_buf
  task automatic launch;
    ccf_w1_in = 1'b1; tk(); ccf_w1_in = 1'b0; tk();
  endtask : launch
  task automatic give_verdict;
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Bounded wait for completion; running out counts as a failure
  task automatic wait_done;
    int n;
    n = 0;
    while (command_complete_flag_out !== 1'b1 && n < 50) begin tk(); n++; end
    if (command_complete_flag_out !== 1'b1) begin err_total++; give_verdict(); end
  endtask : wait_done
  initial begin
    tk(10); rst_in = 1'b0; tk();
    chk1(1'b1, command_complete_flag_out);
    // Field 0 holds the command word; field 3 shows the index steering each access
    wr_idx(3'h0); wr_buf(16'ha5c3); wr_idx(3'h3); wr_buf(16'h1234); tk(2);
    chk16(16'h1234, buf_rd_data_out);
    cie_we_in = 1'b1; cie_data_in = 1'b1; tk(); cie_we_in = 1'b0;
    chk1(1'b1, complete_interrupt_enable_out);
    launch(); chk1(1'b0, command_complete_flag_out);
    chk1(1'b1, exec_active_out);
    // Buffer write lands mid-run, index write on the completing edge: both dropped
    wr_buf(16'hffff); wr_idx(3'h5); wait_done(); tk(2);
    chk16(16'h1234, buf_rd_data_out);
    chk16(16'h0003, {13'h0, parameter_index_field_out});
    chk1(1'b1, cmd_irq_out);
    chk1(1'b0, exec_active_out);
    wr_idx(3'h0); tk(2); chk16(16'h5a3c, buf_rd_data_out);
    wr_idx(3'h5); tk(2); chk16(16'h0000, buf_rd_data_out);
    prereq_ok_in = 1'b0; launch(); chk1(1'b1, access_error_flag_out);
    chk1(1'b1, command_complete_flag_out);
    prereq_ok_in = 1'b1; launch(); chk1(1'b1, command_complete_flag_out);
    err_w1c_in = 1'b1; tk(); err_w1c_in = 1'b0; prot_hit_in = 1'b1; launch(); prot_hit_in = 1'b0;
    chk1(1'b1, protection_violation_flag_out);
    err_w1c_in = 1'b1; pviol_w1c_in = 1'b1; tk(); err_w1c_in = 1'b0; pviol_w1c_in = 1'b0; tk();
    chk1(1'b0, access_error_flag_out | protection_violation_flag_out);
    // Fault on the masked bit first, then on the enabled one
    ecfg_we_in = 1'b1; ecfg_data_in = 2'h1; tk(); ecfg_we_in = 1'b0; efault_set_in = 2'h2; tk();
    efault_set_in = 2'h0; tk(2); chk1(1'b0, err_irq_out);
    chk16(16'h0001, {14'h0, error_config_out});
    chk16(16'h0002, {14'h0, error_status_out});
    efault_set_in = 2'h1; tk(); efault_set_in = 2'h0; tk(2); chk1(1'b1, err_irq_out);
    estat_w1c_in = 2'h3; tk(); estat_w1c_in = 2'h0; tk(2); chk1(1'b0, err_irq_out);
    chk16(16'h0000, {14'h0, error_status_out});
    launch(); rst_in = 1'b1; tk(); rst_in = 1'b0; tk(2);
    chk1(1'b1, command_complete_flag_out);
    give_verdict();
  end
endmodule : testbench
